// ### rtl/arxcdr_defines.vh
// Purpose: shared constants for the serial receive recovery block
// Assumes: included by bare name
// Notes:   definitions only
`ifndef ARXCDR_DEFINES_VH
`define ARXCDR_DEFINES_VH

// ---------------------------------------------------------------
// oversampling
// ---------------------------------------------------------------
`define ARXCDR_OSR_NORM      5'h10
`define ARXCDR_OSR_DBL       5'h08
// first, middle and last vote samples per mode
`define ARXCDR_VOTE_A_NORM   5'h08
`define ARXCDR_VOTE_B_NORM   5'h09
`define ARXCDR_VOTE_C_NORM   5'h0A
`define ARXCDR_VOTE_A_DBL    5'h04
`define ARXCDR_VOTE_B_DBL    5'h05
`define ARXCDR_VOTE_C_DBL    5'h06

// ---------------------------------------------------------------
// frame length (character plus parity)
// ---------------------------------------------------------------
`define ARXCDR_DLEN_MIN      4'h5
`define ARXCDR_DLEN_MAX      4'hA

// ---------------------------------------------------------------
// buffer entry layout: {frame error, data[9:0]}
// ---------------------------------------------------------------
`define ARXCDR_ENT_W         11
`define ARXCDR_ENT_FE_BIT    10
`define ARXCDR_FIFO_DEPTH    4

`endif

// ### rtl/arxcdr_fifo.v
// Purpose: small synchronous FIFO for received frames
// Assumes: single clock, synchronous active-high reset
// Notes:   read data come from a register; flush empties it at once
`timescale 1ns/1ps

module arxcdr_fifo #(
    parameter WIDTH = 11,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    // clock and reset
    input  wire             i_core_clk,
    input  wire             i_rst,
    input  wire             i_flush,
    // write side
    input  wire             i_wr_valid,
    input  wire [WIDTH-1:0] i_wr_data,
    output wire             o_wr_ready,
    // read side
    output wire             o_rd_valid,
    output wire [WIDTH-1:0] o_rd_data,
    input  wire             i_rd_ready
);

    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW-1:0]    wptr_ff;
    reg [AW-1:0]    rptr_ff;
    reg [AW:0]      cnt_ff;
    reg [WIDTH-1:0] head_ff;
    reg             head_vld_ff;

    wire            mem_empty;
    wire            pull;
    wire            wr_fire;
    wire            rd_fire;
    wire [AW:0]     depth_c;

    assign depth_c    = DEPTH[AW:0];
    assign o_wr_ready = (cnt_ff != depth_c);
    assign wr_fire    = i_wr_valid & o_wr_ready;
    assign rd_fire    = head_vld_ff & i_rd_ready;
    assign mem_empty  = (cnt_ff == {(AW+1){1'b0}});
    // head register refills whenever it is free or being taken
    assign pull       = ~mem_empty & (~head_vld_ff | rd_fire);
    assign o_rd_valid = head_vld_ff;
    assign o_rd_data  = head_ff;

    always @(posedge i_core_clk) begin
        if (wr_fire) begin
            mem_ff[wptr_ff] <= i_wr_data;
        end
    end

    always @(posedge i_core_clk) begin
        if (i_rst || i_flush) begin
            wptr_ff     <= {AW{1'b0}};
            rptr_ff     <= {AW{1'b0}};
            cnt_ff      <= {(AW+1){1'b0}};
            head_vld_ff <= 1'b0;
            head_ff     <= {WIDTH{1'b0}};
        end else begin
            if (wr_fire) begin
                wptr_ff <= wptr_ff + 1'b1;
            end
            if (pull) begin
                rptr_ff     <= rptr_ff + 1'b1;
                head_ff     <= mem_ff[rptr_ff];
                head_vld_ff <= 1'b1;
            end else if (rd_fire) begin
                head_vld_ff <= 1'b0;
            end
            if (wr_fire && !pull) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else if (!wr_fire && pull) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end

endmodule

// ### rtl/arxcdr_top.v
// Purpose: asynchronous serial receiver clock and data recovery
// Assumes: i_sample_tick pulses once per oversample period
// Notes:   frames of 5 to 10 bits plus one stop bit go to a FIFO
`timescale 1ns/1ps
`include "arxcdr_defines.vh"

// Summary of operation
// - sample at 16x, or 8x in double speed
// - high-to-low edge starts start detection
// - start judged on samples 8-10 or 4-6
// - majority high start is noise, rearm
// - valid start resynchronises bit timing every frame
// - per-bit state counter 16 or 8 states
// - data and parity bits majority voted
// - stop after first stop bit, ignore rest
// - low first stop bit sets frame error
// - new start accepted right after stop vote
// - frame length five to ten bits
// - ready flag shows unread data present
// - frame error stored with its frame
// - disabling receiver aborts frame, flushes buffer
module arxcdr_top #(
    parameter DLEN_W = 4,
    parameter DEPTH  = `ARXCDR_FIFO_DEPTH
) (
    // clock and reset
    input  wire              i_core_clk,
    input  wire              i_rst,
    // serial line and sample enable
    input  wire              i_rxd,
    input  wire              i_sample_tick,
    // configuration
    input  wire              i_receiver_enable_bit,
    input  wire              i_double_speed_select,
    input  wire [DLEN_W-1:0] i_frame_bits,
    // received data
    input  wire              i_rd_ready,
    output reg               o_rx_complete,
    output reg  [9:0]        o_serial_data_buffer_reg,
    output reg               o_stop_bit_error_flag,
    output reg               o_overrun
);

    // -----------------------------------------------------------
    // states
    // -----------------------------------------------------------
    localparam [2:0] ST_IDLE  = 3'h1;
    localparam [2:0] ST_START = 3'h2;
    localparam [2:0] ST_BITS  = 3'h4;

    // -----------------------------------------------------------
    // input synchroniser
    // -----------------------------------------------------------
    reg        rxd_meta_ff;
    reg        rxd_sync_ff;
    reg        rxd_prev_ff;

    always @(posedge i_core_clk) begin
        if (i_rst) begin
            rxd_meta_ff <= 1'b1;
            rxd_sync_ff <= 1'b1;
        end else begin
            rxd_meta_ff <= i_rxd;
            rxd_sync_ff <= rxd_meta_ff;
        end
    end

    // -----------------------------------------------------------
    // recovery state
    // -----------------------------------------------------------
    reg [2:0]        state_ff;
    reg [2:0]        nxt_state;
    reg [4:0]        samp_ff;
    reg [4:0]        nxt_samp;
    reg [3:0]        bitn_ff;
    reg [3:0]        nxt_bitn;
    reg [1:0]        vote_ff;
    reg [1:0]        nxt_vote;
    reg [9:0]        shift_ff;
    reg [9:0]        nxt_shift;
    reg              push_ff;
    reg              nxt_push;
    reg              fe_ff;
    reg              nxt_fe;
    reg [3:0]        dlen_ff;

    wire [4:0]       osr;
    wire [4:0]       va;
    wire [4:0]       vb;
    wire [4:0]       vc;
    wire             fall;
    wire             bit_val;
    wire [3:0]       dlen_cfg;

    assign osr = i_double_speed_select ? `ARXCDR_OSR_DBL
                                       : `ARXCDR_OSR_NORM;
    assign va = i_double_speed_select ? `ARXCDR_VOTE_A_DBL
                                      : `ARXCDR_VOTE_A_NORM;
    assign vb = i_double_speed_select ? `ARXCDR_VOTE_B_DBL
                                      : `ARXCDR_VOTE_B_NORM;
    assign vc = i_double_speed_select ? `ARXCDR_VOTE_C_DBL
                                      : `ARXCDR_VOTE_C_NORM;

    assign fall = rxd_prev_ff & ~rxd_sync_ff;

    // two of three high samples decide one
    assign bit_val = (vote_ff + {1'b0, rxd_sync_ff}) >= 2'h2;

    // clamp frame length into five to ten
    assign dlen_cfg =
        (i_frame_bits[3:0] < `ARXCDR_DLEN_MIN) ? `ARXCDR_DLEN_MIN :
        (i_frame_bits[3:0] > `ARXCDR_DLEN_MAX) ? `ARXCDR_DLEN_MAX :
        i_frame_bits[3:0];

    // -----------------------------------------------------------
    // sample point decode
    // -----------------------------------------------------------
    wire             at_va;
    wire             at_vb;
    wire             at_vc;
    wire             at_ab;
    wire             at_end;
    wire             last_bit;

    // centre samples share one decode in both phases
    assign at_va    = (samp_ff == va);
    assign at_vb    = (samp_ff == vb);
    assign at_vc    = (samp_ff == vc);
    // first two votes are summed, the third decides
    assign at_ab    = at_va | at_vb;
    // last state of the per-bit sequence
    assign at_end   = (samp_ff == osr);
    // bit counter has reached the first stop bit
    assign last_bit = (bitn_ff == dlen_ff);

    always @* begin
        nxt_state = state_ff;
        nxt_samp  = samp_ff;
        nxt_bitn  = bitn_ff;
        nxt_vote  = vote_ff;
        nxt_shift = shift_ff;
        nxt_push  = 1'b0;
        nxt_fe    = fe_ff;
        if (i_sample_tick) begin
            case (state_ff)
                ST_IDLE: begin
                    nxt_vote = 2'h0;
                    if (fall) begin
                        // this low sample is one, the next one two
                        nxt_state = ST_START;
                        nxt_samp  = 5'h02;
                    end
                end
                ST_START: begin
                    nxt_samp = samp_ff + 5'h01;
                    if (at_ab) begin
                        nxt_vote = vote_ff + {1'b0, rxd_sync_ff};
                    end
                    if (at_vc) begin
                        if (bit_val) begin
                            nxt_state = ST_IDLE;
                        end
                        nxt_vote = 2'h0;
                    end
                    if (at_end) begin
                        // timing now locked to this start
                        nxt_state = ST_BITS;
                        nxt_samp  = 5'h01;
                        nxt_bitn  = 4'h0;
                        nxt_shift = 10'h000;
                    end
                end
                ST_BITS: begin
                    nxt_samp = at_end ? 5'h01
                                      : samp_ff + 5'h01;
                    if (at_ab) begin
                        nxt_vote = vote_ff + {1'b0, rxd_sync_ff};
                    end
                    if (at_vc) begin
                        nxt_vote = 2'h0;
                        if (last_bit) begin
                            // stop bit vote gives frame error
                            nxt_fe    = ~bit_val;
                            nxt_push  = 1'b1;
                            nxt_state = ST_IDLE;
                        end else begin
                            nxt_shift = shift_ff;
                            nxt_shift[bitn_ff] = bit_val;
                            nxt_bitn  = bitn_ff + 4'h1;
                        end
                    end
                end
                default: begin
                    nxt_state = ST_IDLE;
                end
            endcase
        end
    end

    // -----------------------------------------------------------
    // state registers
    // -----------------------------------------------------------
    always @(posedge i_core_clk) begin
        if (i_rst || !i_receiver_enable_bit) begin
            state_ff    <= ST_IDLE;
            samp_ff     <= 5'h00;
            bitn_ff     <= 4'h0;
            vote_ff     <= 2'h0;
            shift_ff    <= 10'h000;
            push_ff     <= 1'b0;
            fe_ff       <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            samp_ff  <= nxt_samp;
            bitn_ff  <= nxt_bitn;
            vote_ff  <= nxt_vote;
            shift_ff <= nxt_shift;
            push_ff  <= nxt_push;
            fe_ff    <= nxt_fe;
        end
    end

    // -----------------------------------------------------------
    // line edge detector
    // -----------------------------------------------------------
    // idles high so re-enabling on a quiet line makes no edge
    always @(posedge i_core_clk) begin
        if (i_rst || !i_receiver_enable_bit) begin
            rxd_prev_ff <= 1'b1;
        end else if (i_sample_tick) begin
            rxd_prev_ff <= rxd_sync_ff;
        end
    end

    // -----------------------------------------------------------
    // frame length
    // -----------------------------------------------------------
    // frozen per frame: a change mid-frame waits for idle
    always @(posedge i_core_clk) begin
        if (i_rst || !i_receiver_enable_bit) begin
            dlen_ff <= `ARXCDR_DLEN_MIN;
        end else if (state_ff == ST_IDLE) begin
            dlen_ff <= dlen_cfg;
        end
    end

    // -----------------------------------------------------------
    // receive buffer
    // -----------------------------------------------------------
    wire [`ARXCDR_ENT_W-1:0] wr_ent;
    wire [`ARXCDR_ENT_W-1:0] rd_ent;
    wire                     wr_ready;
    wire                     rd_valid;
    wire                     rd_take;

    // frame error travels with its data
    assign wr_ent  = {fe_ff, shift_ff};
    assign rd_take = i_rd_ready & o_rx_complete;

    arxcdr_fifo #(
        .WIDTH (`ARXCDR_ENT_W),
        .DEPTH (DEPTH),
        .AW    (2)
    ) u_fifo (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_flush    (~i_receiver_enable_bit),
        .i_wr_valid (push_ff),
        .i_wr_data  (wr_ent),
        .o_wr_ready (wr_ready),
        .o_rd_valid (rd_valid),
        .o_rd_data  (rd_ent),
        .i_rd_ready (rd_take)
    );

    // output stage mirrors FIFO head; valid drops with the take
    always @(posedge i_core_clk) begin
        if (i_rst || !i_receiver_enable_bit) begin
            o_rx_complete            <= 1'b0;
            o_serial_data_buffer_reg <= 10'h000;
            o_stop_bit_error_flag    <= 1'b0;
            o_overrun                <= 1'b0;
        end else begin
            o_rx_complete            <= rd_valid & ~rd_take;
            o_serial_data_buffer_reg <= rd_ent[9:0];
            o_stop_bit_error_flag    <= rd_ent[`ARXCDR_ENT_FE_BIT];
            // full buffer drops the frame; sticky until next good push
            if (push_ff) begin
                o_overrun <= ~wr_ready;
            end
        end
    end

endmodule

// ### test/arxcdr_tx_model.sv
// Purpose: remote serial transmitter model on the receive line
// Assumes: called on a falling edge; bit time is osr*4 clocks + skew
// Notes:   stop bit cut short just past the receiver's vote
`timescale 1ns/1ps
module arxcdr_tx_model (
    input  wire logic i_core_clk,
    output logic      o_line
);
    initial o_line = 1'b1;

    task automatic hold(input logic lvl, input int clks);
        o_line = lvl;
        repeat (clks) @(negedge i_core_clk);
    endtask

    // skew of at most one clock per bit
    task automatic send(input logic [9:0] d, input int len, input logic stp,
                        input int osr, input int skew, input logic glt);
        int bt;
        bt = osr * 4 + skew;
        hold(1'b0, bt);
        for (int k = 0; k < len; k++) begin
            hold(d[k], bt / 2 - 4);
            hold(d[k] ^ glt, 4);
            hold(d[k], bt - bt / 2);
        end
        hold(stp, (osr / 2 + 2) * 4);
    endtask
endmodule

// ### test/arxcdr_checker_assertions.sv
// Purpose: port-level checks of the receive recovery block
// Assumes: one sample tick every 4 clocks
// Notes:   bound to the top module at the foot
`timescale 1ns/1ps
module arxcdr_checker (
    input wire       i_core_clk,
    input wire       i_rst,
    input wire       i_rxd,
    input wire       i_sample_tick,
    input wire       i_receiver_enable_bit,
    input wire       i_rd_ready,
    input wire       o_rx_complete,
    input wire [9:0] o_serial_data_buffer_reg,
    input wire       o_stop_bit_error_flag,
    input wire       o_overrun
);
    reg  [11:0] quiet_ff;
    wire [11:0] nxt_quiet = !i_rxd ? 12'h000 :
                            &quiet_ff ? quiet_ff : quiet_ff + 12'h001;
    always @(posedge i_core_clk) begin
        quiet_ff <= i_rst ? 12'h000 : nxt_quiet;
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    AST_RST_CLR: assert property (disable iff (1'b0) i_rst |=>
        !o_rx_complete && !o_overrun && o_serial_data_buffer_reg == 10'h000)
        else $error("outputs not clear after reset");
    AST_DIS_FLUSH: assert property (!i_receiver_enable_bit |=>
        !o_rx_complete) else $error("buffer kept while disabled");
    AST_DATA_HOLD: assert property (o_rx_complete && !i_rd_ready
        && i_receiver_enable_bit |=> o_rx_complete
        && $stable(o_serial_data_buffer_reg))
        else $error("shown frame changed unread");
    AST_FE_HOLD: assert property ((o_rx_complete && !i_rd_ready
        && i_receiver_enable_bit)[*2] |-> $stable(o_stop_bit_error_flag))
        else $error("error flag left its frame");
    AST_TAKE_GAP: assert property (o_rx_complete && i_rd_ready |=>
        !o_rx_complete) else $error("read did not consume frame");
    AST_RISE_TIME: assert property ($rose(o_rx_complete)
        && !$past(o_rx_complete && i_rd_ready, 2)
        |-> $past(i_sample_tick, 4) || $past(i_sample_tick, 5))
        else $error("frame not pushed after stop vote");
    AST_QUIET: assert property ($rose(o_rx_complete)
        && !$past(o_rx_complete && i_rd_ready, 2) |-> quiet_ff < 12'h3E8)
        else $error("frame without start edge");
    AST_OVR_FULL: assert property ($rose(o_overrun) |->
        o_rx_complete) else $error("overrun with empty buffer");
endmodule

bind arxcdr_top arxcdr_checker arxcdr_checker_i (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_rxd(i_rxd),
    .i_sample_tick(i_sample_tick), .i_rd_ready(i_rd_ready),
    .i_receiver_enable_bit(i_receiver_enable_bit),
    .o_rx_complete(o_rx_complete), .o_overrun(o_overrun),
    .o_serial_data_buffer_reg(o_serial_data_buffer_reg),
    .o_stop_bit_error_flag(o_stop_bit_error_flag));

// ### test/arxcdr_top_tb.sv
// Purpose: self-checking bench of the receive recovery block
// Assumes: sample tick every 4 clocks, inputs driven on falling edge
// Notes:   frames come from the transmitter model
`timescale 1ns/1ps
module arxcdr_top_tb;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       tick = 1'b0;
    logic       en = 1'b1;
    logic       dbl = 1'b0;
    logic       rdy = 1'b0;
    logic [3:0] fbits = 4'h8;
    logic [1:0] tdiv = 2'h0;
    logic       line, cmp, fe, ovr;
    logic [9:0] dat;
    int         errors = 0;
    int         check_count = 0;

    always #20 clk = ~clk;
    always @(negedge clk) begin
        tdiv <= tdiv + 2'h1;
        tick <= (tdiv == 2'h3);
    end

    arxcdr_top arxcdr_top_i (
        .i_core_clk(clk), .i_rst(rst), .i_rxd(line), .i_sample_tick(tick),
        .i_receiver_enable_bit(en), .i_double_speed_select(dbl),
        .i_frame_bits(fbits), .i_rd_ready(rdy), .o_rx_complete(cmp),
        .o_serial_data_buffer_reg(dat), .o_stop_bit_error_flag(fe),
        .o_overrun(ovr));
    arxcdr_tx_model arxcdr_tx_model_i (.i_core_clk(clk), .o_line(line));

    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [10:0] seen,
                       input logic [10:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd(input logic [9:0] d, input logic f);
        int n;
        n = 0;
        while (cmp !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        if (n == 3000) begin
            errors++;
            give_verdict();
        end else begin
            chk("frame", {fe, dat}, {f, d});
            rdy = 1'b1;
            @(negedge clk);
            rdy = 1'b0;
            @(negedge clk);
        end
    endtask

    task automatic snd(input logic [9:0] d, input logic stp);
        arxcdr_tx_model_i.send(d, 8, stp, 16, 0, 0);
        arxcdr_tx_model_i.hold(1'b1, 64);
    endtask

    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        // six lengths back to back, one more than the buffer holds
        for (int l = 5; l <= 10; l++) begin
            fbits = 4'(l);
            arxcdr_tx_model_i.send(10'h2B5 ^ 10'(l), l, 1'b1, 16,
                                   (l < 9) ? l % 2 : 0, 0);
        end
        arxcdr_tx_model_i.hold(1'b1, 64);
        chk("overrun", {10'h000, ovr}, 11'h001);
        for (int l = 5; l <= 9; l++) begin
            rd((10'h2B5 ^ 10'(l)) & ~(10'h3FF << l), 1'b0);
        end
        repeat (20) @(negedge clk);
        chk("drained", {10'h000, cmp}, 11'h000);
        // one flipped centre sample per bit is outvoted
        arxcdr_tx_model_i.send(10'h3C6, 10, 1'b1, 16, 0, 1);
        arxcdr_tx_model_i.hold(1'b1, 64);
        rd(10'h3C6, 1'b0);
        chk("overrun", {10'h000, ovr}, 11'h000);
        fbits = 4'h8;
        snd(10'h0F0, 1'b0);
        snd(10'h00F, 1'b1);
        rd(10'h0F0, 1'b1);
        rd(10'h00F, 1'b0);
        // short low pulse, then a real frame, in both modes
        for (int m = 0; m < 2; m++) begin
            dbl = m[0];
            arxcdr_tx_model_i.hold(1'b0, 8);
            arxcdr_tx_model_i.hold(1'b1, 200);
            chk("noise", {10'h000, cmp}, 11'h000);
            fbits = 4'h9;
            arxcdr_tx_model_i.send(10'h1A5 ^ 10'(m), 9, 1'b1, 16 >> m, 0, 0);
            arxcdr_tx_model_i.hold(1'b1, 64);
            rd(10'h1A5 ^ 10'(m), 1'b0);
        end
        dbl = 1'b0;
        fbits = 4'h8;
        // disable mid-frame with a frame already buffered
        snd(10'h055, 1'b1);
        fork
            snd(10'h0AA, 1'b1);
            begin
                repeat (300) @(negedge clk);
                en = 1'b0;
            end
        join
        chk("flush", {10'h000, cmp}, 11'h000);
        en = 1'b1;
        arxcdr_tx_model_i.hold(1'b1, 8);
        snd(10'h0C3, 1'b1);
        rd(10'h0C3, 1'b0);
        repeat (100) @(negedge clk);
        chk("empty", {10'h000, cmp}, 11'h000);
        give_verdict();
    end
endmodule
